// *** shared/asp_pkg.sv ***
// constants and types for the async serial port controller
`default_nettype none
package asp_pkg;
	// ****************************************
	// register map and field positions
	// ****************************************
	localparam logic [7:0]  OFS_MODE   = 8'h00;
	localparam logic [7:0]  OFS_STA    = 8'h04;
	localparam logic [7:0]  OFS_DIV    = 8'h08;
	localparam logic [7:0]  OFS_TXD    = 8'h0C;
	localparam logic [7:0]  OFS_RXD    = 8'h10;
	localparam logic [15:0] MODE_WMASK = 16'hBBFF;
	localparam logic [15:0] CTL_WMASK  = 16'hFCE0;
	localparam logic [15:0] REG_RST    = 16'h0000;
	localparam int B_ON = 15, B_SIDL = 13, B_IR = 12, B_RTS_PIN_MODE = 11;
	localparam int B_UEN = 8, B_WAKE = 7, B_LPB = 6, B_ABD = 5;
	localparam int B_RXINV = 4, B_FAST = 3, B_FMT = 1, B_STOP = 0;
	localparam int B_TXIS1 = 15, B_TXINV = 14, B_TXIS0 = 13;
	localparam int B_RXEN = 12, B_BRK = 11, B_TXEN = 10, B_TXBF = 9;
	localparam int B_TX_ALL_EMPTY = 8, B_RXIS = 6, B_ADDR = 5, B_RX_IDLE_FLAG = 4;
	localparam int B_PARITY_ERROR_FLAG = 3, B_FRAMING_ERROR_FLAG = 2, B_OVERRUN_FLAG = 1, B_RXDA = 0;
	// ****************************************
	// encodings
	// ****************************************
	localparam logic [1:0] FMT_NINE  = 2'h3;
	localparam logic [1:0] FMT_ODD   = 2'h2;
	localparam logic [1:0] FMT_EVEN  = 2'h1;
	localparam logic [1:0] TXI_ANY   = 2'h0;
	localparam logic [1:0] TXI_DONE  = 2'h1;
	localparam logic [1:0] TXI_EMPTY = 2'h2;
	localparam logic [1:0] RXI_3Q    = 2'h2;
	localparam logic [1:0] RXI_FULL  = 2'h3;
	localparam logic [1:0] UEN_NONE  = 2'h0;
	localparam logic [1:0] UEN_FLOW  = 2'h2;
	localparam logic [1:0] UEN_BCLK  = 2'h3;
	localparam logic [1:0] RESP_OK   = 2'h0;
	localparam logic [1:0] RESP_ERR  = 2'h2;
	// ****************************************
	// timing and frame figures
	// ****************************************
	localparam logic [4:0]  OVS_STD    = 5'h10;
	localparam logic [4:0]  OVS_FAST   = 5'h04;
	localparam logic [4:0]  IR_PULSE   = 5'h03;
	localparam logic [4:0]  TX_MIN_LEN = 5'h0A;
	localparam logic [3:0]  RX_MIN_LEN = 4'h9;
	localparam logic [15:0] BRK_FRAME  = 16'hE000;
	localparam logic [4:0]  BRK_LEN    = 5'h0E;
	localparam logic [2:0]  AB_EDGES   = 3'h5;
	localparam int AB_SH_STD = 7, AB_SH_FAST = 5;
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b01,
		TX_SHIFT = 2'b10
	} asp_tx_t;
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_START = 3'b010,
		RX_DATA  = 3'b100
	} asp_rx_t;
endpackage
`default_nettype wire

// *** src/asp_ctrl.sv ***
// async serial port controller: registers, rate, transmit, receive
// Function
// - infrared codec on: rx pin is ir input, tx pin ir output; 16x only
// - module off releases pins and idles logic; on, pins follow usage
// - stop-in-idle halts operation while chip is idle
// - rts mode: 1 simplex, 0 flow control
// - pin usage field picks rts, cts and bclk pins; tx/rx pins follow their enable bits
// - wake: falling rx edge in sleep signals, next rising edge clears
// - auto rate measures next sync character, then clears itself
// - rx invert: idle 0 when set, 1 when clear
// - fast timing: 4 divisor ticks per bit, else 16
// - frame format: 9n, 8 odd, 8 even, 8n
// - stop count: two stop bits when set, one when clear
// - tx event select: on load, load leaving empty, fully done
// - tx idle level by invert bit, reversed under infrared
// - rx on gives module the rx pin and enables reception
// - break: start, twelve zeros, stop; cleared when sent
// - tx off aborts, flushes buffer, releases tx pin
// - buffer full and all-empty status flags
// - rx event select: full, three entries, any character
// - address mode keeps only bit-8 characters in 9-bit format
// - parity and framing flags follow the head character
// - overrun on overflow; software clear flushes rx state
// - data available and receiver idle flags
// - free-running 16-bit divisor timer sets bit rate
// - divisor write clears the timer at once
// - reading rx data pops to the next character
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`default_nettype none
// ****************************************
// simple fifo, depth a power of two
// ****************************************
module asp_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 4,
	parameter int CW    = 3
) (
	// clock and reset
	input  wire logic          core_clk_i,
	input  wire logic          rst_n_i,
	// control
	input  wire logic          flush_i,
	input  wire logic          push_i,
	input  wire logic          pop_i,
	// data and fill
	input  wire logic [W-1:0]  din_i,
	output logic      [W-1:0]  dout_o,
	output logic      [CW-1:0] cnt_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	wire do_push = push_i & (cnt_o != CW'(DEPTH));
	wire do_pop  = pop_i & (cnt_o != '0);
	assign dout_o = mem[rp];
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || flush_i) begin
			wp <= '0;
			rp <= '0;
			cnt_o <= '0;
		end else begin
			wp <= wp + AW'(do_push);
			rp <= rp + AW'(do_pop);
			cnt_o <= cnt_o + CW'(do_push) - CW'(do_pop);
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (do_push)
			mem[wp] <= din_i;
	end
endmodule

// ****************************************
// controller top
// ****************************************
module asp_ctrl
	import asp_pkg::*;
#(
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// chip power state
	input  wire logic        idle_i,
	input  wire logic        sleep_i,
	// serial pins
	input  wire logic        rx_pin_i,
	input  wire logic        cts_n_i,
	output logic             tx_pin_o,
	output logic             tx_oe_o,
	output logic             rts_pin_o,
	output logic             rts_oe_o,
	output logic             rx_owned_o,
	output logic             cts_owned_o,
	// events
	output logic             tx_irq_o,
	output logic             rx_irq_o,
	output logic             wake_o
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [15:0]   mode, ctl, brg, brg_cnt;
	logic          overrun_flag, rx_m, rx_s, cts_m, cts_s, rx_prev, bclk;
	logic          aw_full, w_full, tx_en_d, tx_brk, wk_seen;
	logic [7:0]    aw_q;
	logic [31:0]   w_q;
	logic [3:0]    s_q, rbits;
	logic [4:0]    tph, rph, tbits, ir_hold, flen;
	logic [15:0]   tx_shift_reg, frame;
	logic [10:0]   rx_shift_reg;
	logic [2:0]    ab_edges;
	logic [23:0]   ab_clk;
	logic [CW-1:0] tx_cnt, rx_cnt;
	logic [8:0]    tx_head;
	logic [10:0]   rx_head;
	asp_tx_t       tx_st;
	asp_rx_t       rx_st;

	// ****************************************
	// bus decode
	// ****************************************
	wire do_wr = aw_full & w_full & ~s_axi_bvalid_o;
	wire rd_hs = s_axi_arvalid_i & s_axi_arready_o;
	wire wr_mode = do_wr & (aw_q == OFS_MODE);
	wire wr_sta  = do_wr & (aw_q == OFS_STA);
	wire wr_div  = do_wr & (aw_q == OFS_DIV);
	wire wr_txd  = do_wr & (aw_q == OFS_TXD) & s_q[0];
	wire wr_hit  = (aw_q == OFS_MODE) | (aw_q == OFS_STA) |
		(aw_q == OFS_DIV) | (aw_q == OFS_TXD) | (aw_q == OFS_RXD);
	wire [15:0] bmask = {{8{s_q[1]}}, {8{s_q[0]}}};
	wire [15:0] mode_w = (mode & ~bmask) | (w_q[15:0] & bmask);
	wire [15:0] ctl_w  = (ctl & ~bmask) | (w_q[15:0] & bmask);
	wire [15:0] brg_w  = (brg & ~bmask) | (w_q[15:0] & bmask);
	assign s_axi_awready_o = ~aw_full;
	assign s_axi_wready_o  = ~w_full;
	assign s_axi_arready_o = ~s_axi_rvalid_o;

	// ****************************************
	// mode decode and pin ownership
	// ****************************************
	wire on    = mode[B_ON];
	wire run   = on & ~(mode[B_SIDL] & idle_i);
	wire ir    = mode[B_IR];
	wire [4:0] ovs = (mode[B_FAST] & ~ir) ? OVS_FAST : OVS_STD;
	wire [1:0] fmt = mode[B_FMT +: 2];
	wire [1:0] uen = mode[B_UEN +: 2];
	wire nine  = fmt == FMT_NINE;
	wire par   = (fmt == FMT_ODD) | (fmt == FMT_EVEN);
	wire tick  = run & (brg_cnt == brg);
	assign tx_oe_o     = on & ctl[B_TXEN];
	assign rx_owned_o  = on & ctl[B_RXEN];
	assign rts_oe_o    = on & (uen != UEN_NONE);
	assign cts_owned_o = on & (uen == UEN_FLOW);

	// ****************************************
	// transmit path
	// ****************************************
	wire tx_kill = ~on | ~ctl[B_TXEN];
	wire tx_flush = ~on | (tx_en_d & ~ctl[B_TXEN]);
	// cts is honoured only when the pin is in use
	wire cts_ok = ~(cts_owned_o & cts_s);
	wire tx_go = (tx_st == TX_IDLE) & run & ~tx_kill &
		(tx_cnt != '0) & cts_ok;
	wire tx_bend = (tx_st == TX_SHIFT) & tick & (tph == ovs - 5'h01);
	wire tx_done = tx_bend & (tbits == 5'h01);
	wire tx_busy = tx_st == TX_SHIFT;
	wire lb = tx_busy ? tx_shift_reg[0] : 1'b1;
	wire ir_tx = tx_busy & ~tx_shift_reg[0] & (tph < IR_PULSE);
	wire pbit = (^tx_head[7:0]) ^ (fmt == FMT_ODD);
	wire tx_all_empty = ~tx_busy & (tx_cnt == '0);
	logic tx_irq_n;

	asp_fifo #(.W(9), .DEPTH(DEPTH), .CW(CW)) u_txf (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.flush_i    (tx_flush),
		.push_i     (wr_txd),
		.pop_i      (tx_go),
		.din_i      (w_q[8:0]),
		.dout_o     (tx_head),
		.cnt_o      (tx_cnt)
	);

	always_comb begin
		frame = 16'hFFFF;
		frame[8:0] = {tx_head[7:0], 1'b0};
		frame[9] = nine ? tx_head[8] : (par ? pbit : 1'b1);
		flen = TX_MIN_LEN + {4'h0, nine | par} +
			{4'h0, mode[B_STOP]};
		if (ctl[B_BRK]) begin
			frame = BRK_FRAME;
			flen = BRK_LEN;
		end
	end

	always_comb begin
		case ({ctl[B_TXIS1], ctl[B_TXIS0]})
			TXI_ANY:   tx_irq_n = tx_go;
			TXI_EMPTY: tx_irq_n = tx_go & (tx_cnt == CW'(1));
			TXI_DONE:  tx_irq_n = tx_done & (tx_cnt == '0);
			default:   tx_irq_n = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || tx_kill) begin
			tx_st <= TX_IDLE;
			tph <= '0;
			tbits <= '0;
			tx_shift_reg <= 16'hFFFF;
			tx_brk <= 1'b0;
		end else if (tx_go) begin
			tx_st <= TX_SHIFT;
			tph <= '0;
			tx_shift_reg <= frame;
			tbits <= flen;
			tx_brk <= ctl[B_BRK];
		end else if (tx_bend) begin
			tph <= '0;
			tx_shift_reg <= {1'b1, tx_shift_reg[15:1]};
			tbits <= tbits - 5'h01;
			if (tx_done)
				tx_st <= TX_IDLE;
		end else if (tick && tx_busy) begin
			tph <= tph + 5'h01;
		end
	end

	// ****************************************
	// receive path
	// ****************************************
	wire rxl = rx_s ^ mode[B_RXINV];
	wire ir_line = rxl & (ir_hold == '0);
	wire rx_line = mode[B_LPB] ? lb : (ir ? ir_line : rxl);
	wire rx_flush = wr_sta & overrun_flag & ~ctl_w[B_OVERRUN_FLAG];
	wire rx_kill = ~on | ~ctl[B_RXEN] | rx_flush;
	wire [3:0] nb = RX_MIN_LEN + {3'h0, nine | par};
	wire rx_bend = (rx_st == RX_DATA) & tick & (rph == ovs - 5'h01);
	wire rx_fin = rx_bend & (rbits == nb - 4'h1);
	wire [10:0] cap = {rx_line, rx_shift_reg[10:1]};
	wire [10:0] ext = (nb == RX_MIN_LEN) ? {1'b0, cap[10:1]} : cap;
	wire [8:0] rdat = {nine & ext[9], ext[8:1]};
	wire r_parity_error_flag = par & (ext[9] != ((^ext[8:1]) ^ (fmt == FMT_ODD)));
	wire r_framing_error_flag = ~cap[10];
	wire keep = ~(ctl[B_ADDR] & nine & ~ext[9]);
	wire rx_full = rx_cnt == CW'(DEPTH);
	wire rx_push = rx_fin & keep & ~rx_full;
	wire ovf = rx_fin & keep & rx_full;
	wire rxda = rx_cnt != '0;
	wire rx_pop = rd_hs & (s_axi_araddr_i == OFS_RXD);
	wire [CW-1:0] rx_next = rx_cnt + CW'(1);
	logic rx_irq_n;

	asp_fifo #(.W(11), .DEPTH(DEPTH), .CW(CW)) u_rxf (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.flush_i    (rx_kill),
		.push_i     (rx_push),
		.pop_i      (rx_pop),
		.din_i      ({r_framing_error_flag, r_parity_error_flag, rdat}),
		.dout_o     (rx_head),
		.cnt_o      (rx_cnt)
	);

	always_comb begin
		case (ctl[B_RXIS +: 2])
			RXI_FULL: rx_irq_n = rx_push & (rx_next == CW'(DEPTH));
			RXI_3Q:   rx_irq_n = rx_push & (rx_next == CW'(DEPTH - 1));
			default:  rx_irq_n = rx_push;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || rx_kill) begin
			rx_st <= RX_IDLE;
			rph <= '0;
			rbits <= '0;
			rx_shift_reg <= '0;
		end else begin
			case (rx_st)
				RX_IDLE: begin
					// auto rate owns the line while it measures
					if (tick && !rx_line && !mode[B_ABD]) begin
						rx_st <= RX_START;
						rph <= '0;
					end
				end
				RX_START: begin
					if (tick && rph == (ovs >> 1) - 5'h01) begin
						rx_st <= rx_line ? RX_IDLE : RX_DATA;
						rph <= '0;
						rbits <= '0;
					end else if (tick) begin
						rph <= rph + 5'h01;
					end
				end
				RX_DATA: begin
					if (rx_bend) begin
						rph <= '0;
						rx_shift_reg <= cap;
						rbits <= rbits + 4'h1;
						if (rx_fin)
							rx_st <= RX_IDLE;
					end else if (tick) begin
						rph <= rph + 5'h01;
					end
				end
				default: rx_st <= RX_IDLE;
			endcase
		end
	end

	// ****************************************
	// auto rate and wake
	// ****************************************
	wire fall = rx_prev & ~rx_line;
	wire rise = ~rx_prev & rx_line;
	wire ab_end = mode[B_ABD] & run & fall &
		(ab_edges == AB_EDGES - 3'h1);
	wire [23:0] ab_q = ab_clk >> (mode[B_FAST] ? AB_SH_FAST : AB_SH_STD);
	wire [15:0] ab_brg = (ab_q[15:0] == '0) ? '0 : ab_q[15:0] - 16'h0001;
	wire wk_fall = mode[B_WAKE] & sleep_i & fall;
	wire wk_clr = mode[B_WAKE] & wk_seen & rise;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || !mode[B_ABD] || !run) begin
			ab_edges <= '0;
			ab_clk <= '0;
		end else begin
			if (fall)
				ab_edges <= ab_edges + 3'h1;
			if (ab_edges != '0)
				ab_clk <= ab_clk + 24'h000001;
		end
	end

	// ****************************************
	// registers and rate timer
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			mode <= REG_RST;
			ctl <= REG_RST;
			brg <= REG_RST;
			overrun_flag <= 1'b0;
			wk_seen <= 1'b0;
		end else begin
			if (wr_mode)
				mode <= mode_w & MODE_WMASK;
			else begin
				if (ab_end)
					mode[B_ABD] <= 1'b0;
				if (wk_clr)
					mode[B_WAKE] <= 1'b0;
			end
			if (wr_sta)
				ctl <= ctl_w & CTL_WMASK;
			else if (tx_done && tx_brk)
				ctl[B_BRK] <= 1'b0;
			if (wr_div)
				brg <= brg_w;
			else if (ab_end)
				brg <= ab_brg;
			// an overflow in the clearing cycle keeps the flag
			overrun_flag <= ovf | (overrun_flag & ~rx_flush);
			wk_seen <= mode[B_WAKE] & (wk_seen | wk_fall) & ~wk_clr;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || wr_div || ab_end || !run || tick)
			brg_cnt <= '0;
		else
			brg_cnt <= brg_cnt + 16'h0001;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rx_m <= 1'b1;
			rx_s <= 1'b1;
			cts_m <= 1'b1;
			cts_s <= 1'b1;
			rx_prev <= 1'b1;
			ir_hold <= '0;
			tx_en_d <= 1'b0;
			bclk <= 1'b0;
			tx_pin_o <= 1'b1;
			rts_pin_o <= 1'b1;
			tx_irq_o <= 1'b0;
			rx_irq_o <= 1'b0;
			wake_o <= 1'b0;
		end else begin
			rx_m <= rx_pin_i;
			rx_s <= rx_m;
			cts_m <= cts_n_i;
			cts_s <= cts_m;
			rx_prev <= rx_line;
			if (!rxl)
				ir_hold <= OVS_STD;
			else if (tick && ir_hold != '0)
				ir_hold <= ir_hold - 5'h01;
			tx_en_d <= ctl[B_TXEN];
			bclk <= on & (brg_cnt <= (brg >> 1));
			tx_pin_o <= (ir ? ir_tx : lb) ^ ctl[B_TXINV];
			if (uen == UEN_BCLK)
				rts_pin_o <= bclk;
			else if (mode[B_RTS_PIN_MODE])
				rts_pin_o <= tx_all_empty;
			else
				rts_pin_o <= rx_full;
			tx_irq_o <= tx_irq_n;
			rx_irq_o <= rx_irq_n;
			wake_o <= wk_fall;
		end
	end

	// ****************************************
	// bus slave
	// ****************************************
	logic [15:0] sta_rd, rd_mux;
	always_comb begin
		sta_rd = ctl;
		sta_rd[B_TXBF] = tx_cnt == CW'(DEPTH);
		sta_rd[B_TX_ALL_EMPTY] = tx_all_empty;
		sta_rd[B_RX_IDLE_FLAG] = rx_st == RX_IDLE;
		sta_rd[B_PARITY_ERROR_FLAG] = rxda & rx_head[9];
		sta_rd[B_FRAMING_ERROR_FLAG] = rxda & rx_head[10];
		sta_rd[B_OVERRUN_FLAG] = overrun_flag;
		sta_rd[B_RXDA] = rxda;
		case (s_axi_araddr_i)
			OFS_MODE: rd_mux = mode;
			OFS_STA:  rd_mux = sta_rd;
			OFS_DIV:  rd_mux = brg;
			OFS_RXD:  rd_mux = {7'h00, rx_head[8:0]};
			default:  rd_mux = '0;
		endcase
	end

	wire rd_hit = (s_axi_araddr_i == OFS_MODE) |
		(s_axi_araddr_i == OFS_STA) | (s_axi_araddr_i == OFS_DIV) |
		(s_axi_araddr_i == OFS_RXD);

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_q <= '0;
			w_q <= '0;
			s_q <= '0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OK;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rresp_o <= RESP_OK;
			s_axi_rdata_o <= '0;
		end else begin
			if (s_axi_awvalid_i && !aw_full) begin
				aw_full <= 1'b1;
				aw_q <= s_axi_awaddr_i;
			end else if (do_wr)
				aw_full <= 1'b0;
			if (s_axi_wvalid_i && !w_full) begin
				w_full <= 1'b1;
				w_q <= s_axi_wdata_i;
				s_q <= s_axi_wstrb_i;
			end else if (do_wr)
				w_full <= 1'b0;
			if (do_wr) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_hit ? RESP_OK : RESP_ERR;
			end else if (s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
			if (rd_hs) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= {16'h0000, rd_mux};
				s_axi_rresp_o <= rd_hit ? RESP_OK : RESP_ERR;
			end else if (s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** verif/asp_ctrl_assertions.sv ***
// port checker for the serial port controller
`default_nettype none
module asp_ctrl_assertions
	import asp_pkg::*;
(
	// clock, reset and register bus
	input wire logic        core_clk_i,
	input wire logic        rst_n_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [7:0]  s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// events
	input wire logic        tx_irq_o,
	input wire logic        rx_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic wr_go = s_axi_awvalid_i && s_axi_awready_o
		&& s_axi_wvalid_i && s_axi_wready_o;
	wire logic rd_go = s_axi_arvalid_i && s_axi_arready_o;
	wire logic rd_bad = !(s_axi_araddr_i inside
		{OFS_MODE, OFS_STA, OFS_DIV, OFS_TXD, OFS_RXD});
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o) else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer not held");
	ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while busy");
	rd_lat_a: assert property (rd_go |=> s_axi_rvalid_o)
		else $error("read answer late");
	rd_bad_a: assert property (rd_go && rd_bad |=> s_axi_rresp_o
		== RESP_ERR && s_axi_rdata_o == 32'h0000_0000)
		else $error("unmapped read accepted");
	rd_top_a: assert property (s_axi_rvalid_o
		|-> s_axi_rdata_o[31:16] == 16'h0000) else $error("upper half set");
	wr_walk_a: assert property (wr_go |=> !s_axi_awready_o
		&& !s_axi_wready_o ##1 s_axi_bvalid_o)
		else $error("write answer out of step");
	tx_once_a: assert property (tx_irq_o |=> !tx_irq_o)
		else $error("tx event too long");
	rx_once_a: assert property (rx_irq_o |=> !rx_irq_o)
		else $error("rx event too long");
endmodule
bind asp_ctrl asp_ctrl_assertions chk (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .tx_irq_o(tx_irq_o),
	.rx_irq_o(rx_irq_o)
);
`default_nettype wire

// *** verif/asp_ctrl_tb_top.sv ***
// self-checking bench for the serial port controller
`default_nettype none
`define CHK(nm, e, g) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("mismatch %s exp %0h got %0h", nm, e, g); \
	end \
end
module asp_ctrl_tb_top
	import asp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'h0, rst_n = 1'h0, sleep = 1'h0, idle = 1'h0;
	logic        awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0000_0000, rdat, d;
	logic        awr, wrr, bv, arr, rv, tx_pin, tx_oe, rx_line, cts_n;
	logic        rx_irq, wake, tx_irq, rts_pin, rts_oe, rx_owned, cts_own;
	logic [1:0]  br, rr, r;
	logic [15:0] v, f, g;
	int          error_cnt = 0, n_tests = 0, n_rxi = 0, n_wk = 0;
	int          n_txi = 0;
	int          fm, st, n, k;
	int          q[$];
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		n_rxi <= n_rxi + int'(rx_irq);
		n_wk <= n_wk + int'(wake);
		n_txi <= n_txi + int'(tx_irq);
	end
	asp_ctrl dut (
		.core_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rrdy), .idle_i(idle), .sleep_i(sleep),
		.rx_pin_i(rx_line), .cts_n_i(cts_n), .tx_pin_o(tx_pin),
		.tx_oe_o(tx_oe), .rts_pin_o(rts_pin), .rts_oe_o(rts_oe),
		.rx_owned_o(rx_owned), .cts_owned_o(cts_own), .tx_irq_o(tx_irq),
		.rx_irq_o(rx_irq), .wake_o(wake)
	);
	asp_station stn (.core_clk_i(clk), .tx_line_i(tx_pin),
		.rx_line_o(rx_line), .cts_n_o(cts_n));
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] x);
		@(posedge clk);
		awa <= a;
		wd <= {16'h0000, x};
		awv <= 1'h1;
		wv <= 1'h1;
		brdy <= 1'h1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge clk);
			if (awr) awv <= 1'h0;
			if (wrr) wv <= 1'h0;
		end while (!bv);
		r = br;
		brdy <= 1'h0;
	endtask
	task automatic bus_rd(input logic [7:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'h1;
		rrdy <= 1'h1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'h0;
		end while (!rv);
		d = rdat;
		r = rr;
		rrdy <= 1'h0;
	endtask
	// start at bit 0, data, parity, stop bits; len counts them all
	function automatic logic [15:0] frame(input logic [15:0] x,
		output int len);
		int nb;
		nb = (fm == 3) ? 9 : 8;
		frame = 16'h0000;
		for (int i = 0; i < nb; i++) frame[i + 1] = x[i];
		if (fm == 1 || fm == 2) begin
			frame[9] = ^x[7:0] ^ (fm == 2);
			nb++;
		end
		frame[nb + 1] = 1'h1;
		frame[nb + 2] = st[0];
		len = nb + 2 + st;
	endfunction
	task automatic final_report;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100us;
		error_cnt++;
		final_report();
	end
	initial begin
		v = 16'($urandom(48));
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		bus_rd(OFS_STA);
		`CHK("sta_rst", 32'h0000_0110, d)
		bus_rd(8'h14);
		`CHK("rd_bad", RESP_ERR, r)
		bus_wr(8'h18, 16'h1234);
		`CHK("wr_bad", RESP_ERR, r)
		bus_wr(OFS_STA, 16'h1400);
		for (int c = 0; c < 8; c++) begin
			fm = c % 4;
			st = c / 4;
			// fast timing on divisor 3 must keep the same 16-clock bit
			bus_wr(OFS_DIV, 16'(3 * st));
			bus_wr(OFS_MODE, 16'(32'h8000 | fm << 1 | st | st << 3));
			v = 16'($urandom) & ((fm == 3) ? 16'h01ff : 16'h00ff);
			f = frame(v, n);
			bus_wr(OFS_TXD, v);
			stn.grab(n, 16, g);
			`CHK("tx_frame", f, g)
			k = (c == 1 || c == 4) ? 32'h0200 : 0;
			q.push_back(v);
			stn.send(f ^ 16'(k), n, 16);
			bus_rd(OFS_STA);
			`CHK("sta_rx", 32'h1511 | (c == 1) << 3 | (c == 4) << 2, d)
			`CHK("rx_own", 1'h1, rx_owned)
			bus_rd(OFS_RXD);
			k = q.pop_front();
			`CHK("rx_data", 32'(k), d)
		end
		`CHK("rx_any_evt", 8, n_rxi)
		`CHK("tx_any_evt", 8, n_txi)
		bus_wr(OFS_DIV, 16'h0000);
		bus_wr(OFS_MODE, 16'h8000);
		bus_wr(OFS_STA, 16'h14c0);
		fm = 0;
		st = 0;
		k = n_rxi;
		for (int c = 0; c < 5; c++) begin
			v = 16'($urandom) & 16'h00ff;
			if (q.size() < 4) q.push_back(v);
			f = frame(v, n);
			stn.send(f, n, 16);
		end
		`CHK("rx_full_evt", 1, n_rxi - k)
		bus_rd(OFS_STA);
		`CHK("overrun", 32'h0000_15d3, d)
		bus_rd(OFS_RXD);
		k = q.pop_front();
		`CHK("rx_head", 32'(k), d)
		bus_wr(OFS_STA, 16'h14c0);
		q.delete();
		bus_rd(OFS_STA);
		`CHK("rx_flushed", 32'h0000_15d0, d)
		bus_wr(OFS_STA, 16'h0000);
		repeat (4) bus_wr(OFS_TXD, 16'h0055);
		bus_rd(OFS_STA);
		`CHK("tx_full", 2'h2, d[9:8])
		// a stopped module must leave the queued frames untouched
		idle <= 1'h1;
		bus_wr(OFS_MODE, 16'ha000);
		bus_wr(OFS_STA, 16'h0400);
		bus_rd(OFS_STA);
		`CHK("idle_hold", 2'h2, d[9:8])
		idle <= 1'h0;
		bus_wr(OFS_STA, 16'h0000);
		bus_rd(OFS_STA);
		`CHK("tx_abort", 2'h1, d[9:8])
		`CHK("tx_release", 1'h0, tx_oe)
		bus_wr(OFS_STA, 16'h0c00);
		bus_wr(OFS_TXD, 16'h0000);
		stn.grab(14, 16, g);
		`CHK("break", 16'h2000, g)
		bus_rd(OFS_STA);
		`CHK("break_clr", 1'h0, d[11])
		k = n_wk;
		bus_wr(OFS_MODE, 16'h8280);
		sleep <= 1'h1;
		stn.send(16'h0004, 3, 16);
		bus_rd(OFS_MODE);
		`CHK("wake_evt", 1, n_wk - k)
		`CHK("wake_clr", 32'h0000_8200, d)
		`CHK("pin_use", 3'h6, {rts_oe, cts_own, rts_pin})
		final_report();
	end
endmodule
`default_nettype wire

// *** verif/asp_station.sv ***
// far-side serial station: drives the rx line, samples the tx line
`default_nettype none
module asp_station (
	// clock
	input  wire logic core_clk_i,
	// line side
	input  wire logic tx_line_i,
	output logic      rx_line_o,
	output logic      cts_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_line_o = 1'h1;
		cts_n_o = 1'h0;
	end
	// frame bit 0 goes first; the line idles high afterwards
	task automatic send(input logic [15:0] f, input int n, input int per);
		for (int i = 0; i < n; i++) begin
			rx_line_o <= f[i];
			repeat (per) @(posedge core_clk_i);
		end
		rx_line_o <= 1'h1;
		// one idle edge so a following frame never re-drives this step
		@(posedge core_clk_i);
	endtask
	// half a bit after the first low, so a late look still lands mid-bit
	task automatic grab(input int n, input int per, output logic [15:0] f);
		f = 16'h0000;
		for (int i = 0; i < 3000 && tx_line_i !== 1'h0; i++)
			@(posedge core_clk_i);
		repeat (per / 2) @(posedge core_clk_i);
		for (int i = 0; i < n; i++) begin
			f[i] = tx_line_i;
			repeat (per) @(posedge core_clk_i);
		end
	endtask
endmodule
`default_nettype wire
